/* File: core/adcs_defs.svh */
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// Function
// - Scan is start to end channel ascending
// - Software start one sample; trigger whole scan
// - Burst uses start channel nybble only
// - Write offset 0 converts current, advances
// - Burst converts every two microseconds
// - Timed scan per counter timeout, oversampled
// - Offset 1A sets oversample, enables timed
// - Offset 1B 01/03 starts timed scans
// - Offset 1B 00/02 arms external start
// - First external start edge only begins
// - One scan per external trigger edge
// - Offset 1C 02 arms, 00 suspends
// - Read 1D resets acquisition logic
// - Conversions equal channels times oversample
// - Offset 2 holds end/start nybbles
// - Pointer wraps past end to start
// - Offset A reads pointer; limit write reloads
// - Per-channel gain codes, unity reset
// - Conversions fill FIFO; empty bit; pops
// - Offset 3 01 starts, 00 stops burst
// - Offset 1E 40 pre-enables counter gates
// - Full FIFO pauses, resumes after reads
// - FIFO 1024 deep with half-full flag

// ****************************************
// Register offsets
// ****************************************
`define ADCS_OFS_START 5'h00
`define ADCS_OFS_LIMITS 5'h02
`define ADCS_OFS_BURST 5'h03
`define ADCS_OFS_GAIN_LO 5'h04
`define ADCS_OFS_GAIN_HI 5'h06
`define ADCS_OFS_GAIN_RST 5'h07
`define ADCS_OFS_STATUS 5'h08
`define ADCS_OFS_CHAN 5'h0a
`define ADCS_OFS_OVS 5'h1a
`define ADCS_OFS_CNT_START 5'h1b
`define ADCS_OFS_EXT_CTRL 5'h1c
`define ADCS_OFS_RESET 5'h1d
`define ADCS_OFS_GATE 5'h1e
`define ADCS_OFS_FIFO 5'h00

// ****************************************
// Command values and field positions
// ****************************************
`define ADCS_OVS_1 8'h11
`define ADCS_OVS_2 8'h91
`define ADCS_OVS_8 8'h90
`define ADCS_OVS_16 8'h10
`define ADCS_CNT_RUN_12 8'h01
`define ADCS_CNT_RUN_0 8'h03
`define ADCS_CNT_ARM_12 8'h00
`define ADCS_CNT_ARM_0 8'h02
`define ADCS_EXT_ARM 8'h02
`define ADCS_EXT_SUSPEND 8'h00
`define ADCS_BURST_ON 8'h01
`define ADCS_BURST_OFF 8'h00
`define ADCS_GATE_ON 8'h40
`define ADCS_ST_EMPTY 0
`define ADCS_ST_HALF 1
`define ADCS_ST_FULL 2
`define ADCS_GAIN_UNITY 32'h0000_0000

// ****************************************
// Timing
// ****************************************
`define ADCS_CLK_MHZ 100
`define ADCS_BURST_NS 2000
`define ADCS_BURST_CYC ((`ADCS_BURST_NS * `ADCS_CLK_MHZ) / 1000)
`endif

/* File: core/adcs_pkg.sv */
package adcs_pkg;
  // Acquisition modes
  typedef enum logic [2:0] {
    ADCS_MODE_IDLE,
    ADCS_MODE_BURST,
    ADCS_MODE_TIMED,
    ADCS_MODE_EXT_START,
    ADCS_MODE_EXT_TRIG
  } adcs_mode_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ADCS_SQ_IDLE,
    ADCS_SQ_REQ,
    ADCS_SQ_WAIT
  } adcs_state_t;
  // Host I/O access
  typedef struct packed {
    logic wr8;
    logic rd8;
    logic rd16;
    logic wr16;
    logic [4:0] addr;
    logic [15:0] wdata;
  } adcs_io_t;
  // Converter request to the analog front end
  typedef struct packed {
    logic start;
    logic [3:0] chan;
    logic [1:0] gain;
  } adcs_conv_t;
endpackage

/* File: core/adcs_seq.sv */
`timescale 1ns/1ns
`include "adcs_defs.svh"
module adcs_seq
  import adcs_pkg::*;
#(
  parameter int FIFO_DEPTH = 1024,
  parameter int DATA_W = 16
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire adcs_io_t io_in,
  output logic [15:0] rdata_out,
  input wire logic cnt0_out_in,
  input wire logic cnt12_out_in,
  input wire logic ext_start_in,
  input wire logic ext_trig_in,
  output adcs_conv_t conv_out,
  input wire logic conv_done_in,
  input wire logic [DATA_W-1:0] conv_data_in,
  output logic gate_enable_out,
  output logic fifo_half_full_flag_out
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int BCW = 8;
  localparam logic [BCW-1:0] BURST_CYC = BCW'(`ADCS_BURST_CYC);

  // ****************************************
  // Register decode
  // ****************************************
  wire wr_start = io_in.wr8 && io_in.addr == `ADCS_OFS_START;
  wire wr_limits = io_in.wr8 && io_in.addr == `ADCS_OFS_LIMITS;
  wire wr_burst = io_in.wr8 && io_in.addr == `ADCS_OFS_BURST;
  wire wr_gain_lo = io_in.wr16 && io_in.addr == `ADCS_OFS_GAIN_LO;
  wire wr_gain_hi = io_in.wr16 && io_in.addr == `ADCS_OFS_GAIN_HI;
  wire wr_gain_rst = io_in.wr8 && io_in.addr == `ADCS_OFS_GAIN_RST;
  wire wr_ovs = io_in.wr8 && io_in.addr == `ADCS_OFS_OVS;
  wire wr_cnt = io_in.wr8 && io_in.addr == `ADCS_OFS_CNT_START;
  wire wr_ext = io_in.wr8 && io_in.addr == `ADCS_OFS_EXT_CTRL;
  wire wr_gate = io_in.wr8 && io_in.addr == `ADCS_OFS_GATE;
  wire rd_fifo = io_in.rd16 && io_in.addr == `ADCS_OFS_FIFO;
  // Read of the reset offset clears the acquisition path except the trigger synchronisers and output registers
  wire soft_rst = io_in.rd8 && io_in.addr == `ADCS_OFS_RESET;
  wire [7:0] wb = io_in.wdata[7:0];

  // ****************************************
  // Register state
  // ****************************************
  logic [3:0] start_ch_r, end_ch_r, chan_r;
  logic [31:0] gain_r;
  adcs_mode_t mode_r;
  logic [4:0] ovs_n_r;
  logic timed_en_r, use_c0_r, ext_started_r, ext_run_r;
  logic gate_r;

  // Oversample code to count
  function automatic logic [4:0] ovs_count(input logic [7:0] code);
    if (code == `ADCS_OVS_2) ovs_count = 5'h02;
    else if (code == `ADCS_OVS_8) ovs_count = 5'h08;
    else if (code == `ADCS_OVS_16) ovs_count = 5'h10;
    else ovs_count = 5'h01;
  endfunction

  // ****************************************
  // Trigger synchronisers and edges
  // ****************************************
  logic [2:0] s_c0, s_c12, s_es, s_et;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_c0 <= 3'h0;
      s_c12 <= 3'h0;
      s_es <= 3'h0;
      s_et <= 3'h0;
    end else begin
      s_c0 <= {s_c0[1:0], cnt0_out_in};
      s_c12 <= {s_c12[1:0], cnt12_out_in};
      s_es <= {s_es[1:0], ext_start_in};
      s_et <= {s_et[1:0], ext_trig_in};
    end
  end
  // Edges read only stages 1 and 2, never the first flop
  wire c0_rise = s_c0[1] && !s_c0[2];
  wire c12_rise = s_c12[1] && !s_c12[2];
  wire es_rise = s_es[1] && !s_es[2];
  wire et_rise = s_et[1] && !s_et[2];

  // ****************************************
  // Sample FIFO
  // ****************************************
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  wire f_full = cnt_r == (AW+1)'(FIFO_DEPTH);
  wire f_empty = cnt_r == '0;
  wire f_push = conv_done_in && !f_full;
  wire f_pop = rd_fifo && !f_empty;
  always_ff @(posedge mclk_in) begin
    if (f_push) mem[wp_r] <= conv_data_in;
  end
  // Pointer and level bookkeeping
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || soft_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (f_push) wp_r <= wp_r + 1'b1;
      if (f_pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(f_push) - (AW+1)'(f_pop);
    end
  end
  wire f_half = cnt_r >= (AW+1)'(FIFO_DEPTH/2);

  // ****************************************
  // Scan sequencer
  // ****************************************
  adcs_state_t st_r;
  logic [4:0] ovs_left_r;
  logic in_scan_r;
  logic [BCW-1:0] bcnt_r;
  wire at_end = chan_r == end_ch_r;
  // Next channel with wrap past the end back to start
  wire [3:0] ch_next = at_end ? start_ch_r : chan_r + 4'h1;
  wire timer_tick = use_c0_r ? c0_rise : c12_rise;
  wire burst_tick = mode_r == ADCS_MODE_BURST && bcnt_r == '0;
  // A scan request is dropped while another scan runs
  wire scan_go = !in_scan_r && (
    (timed_en_r && mode_r == ADCS_MODE_TIMED && timer_tick) ||
    (timed_en_r && mode_r == ADCS_MODE_EXT_START && ext_started_r && timer_tick) ||
    (mode_r == ADCS_MODE_EXT_TRIG && ext_run_r && et_rise));
  wire single_go = wr_start && !in_scan_r && mode_r == ADCS_MODE_IDLE;
  // Full FIFO holds the request stage off until a read makes room
  wire may_req = !f_full;
  wire done_conv = st_r == ADCS_SQ_WAIT && conv_done_in;
  wire last_ovs = ovs_left_r == 5'h01;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || soft_rst) begin
      bcnt_r <= '0;
    end else if (mode_r != ADCS_MODE_BURST || bcnt_r == '0) begin
      bcnt_r <= BURST_CYC - 1'b1;
    end else begin
      bcnt_r <= bcnt_r - 1'b1;
    end
  end

  // Conversion flow; pending burst tick waits behind a busy converter
  logic burst_pend_r;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || soft_rst) begin
      st_r <= ADCS_SQ_IDLE;
      in_scan_r <= 1'b0;
      ovs_left_r <= 5'h01;
      burst_pend_r <= 1'b0;
    end else if (wr_burst && wb != `ADCS_BURST_ON && !in_scan_r && st_r != ADCS_SQ_WAIT) begin
      // Stopping burst drops a request parked behind a full FIFO
      st_r <= ADCS_SQ_IDLE;
      burst_pend_r <= 1'b0;
    end else begin
      if (burst_tick) burst_pend_r <= 1'b1;
      else if (mode_r != ADCS_MODE_BURST) burst_pend_r <= 1'b0;
      case (st_r)
        ADCS_SQ_IDLE: begin
          if (scan_go) begin
            in_scan_r <= 1'b1;
            ovs_left_r <= ovs_n_r;
            st_r <= ADCS_SQ_REQ;
          end else if (single_go) begin
            ovs_left_r <= 5'h01;
            st_r <= ADCS_SQ_REQ;
          end else if ((burst_pend_r && mode_r == ADCS_MODE_BURST) || burst_tick) begin
            burst_pend_r <= 1'b0;
            ovs_left_r <= 5'h01;
            st_r <= ADCS_SQ_REQ;
          end
        end
        ADCS_SQ_REQ: begin
          if (may_req) st_r <= ADCS_SQ_WAIT;
        end
        ADCS_SQ_WAIT: begin
          if (conv_done_in) begin
            if (in_scan_r && !last_ovs) begin
              ovs_left_r <= ovs_left_r - 5'h01;
              st_r <= ADCS_SQ_REQ;
            end else if (in_scan_r && !at_end) begin
              ovs_left_r <= ovs_n_r;
              st_r <= ADCS_SQ_REQ;
            end else begin
              in_scan_r <= 1'b0;
              st_r <= ADCS_SQ_IDLE;
            end
          end
        end
        default: st_r <= ADCS_SQ_IDLE;
      endcase
    end
  end

  // Channel pointer
  wire chan_step = done_conv && mode_r != ADCS_MODE_BURST && (!in_scan_r || last_ovs);
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || soft_rst) begin
      chan_r <= 4'h0;
    end else if (wr_limits) begin
      chan_r <= wb[3:0];
    end else if (mode_r == ADCS_MODE_BURST) begin
      chan_r <= start_ch_r;
    end else if (chan_step) begin
      chan_r <= ch_next;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || soft_rst) begin
      start_ch_r <= 4'h0;
      end_ch_r <= 4'h0;
      mode_r <= ADCS_MODE_IDLE;
      ovs_n_r <= 5'h01;
      timed_en_r <= 1'b0;
      use_c0_r <= 1'b0;
      ext_started_r <= 1'b0;
      ext_run_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      if (wr_limits) begin
        start_ch_r <= wb[3:0];
        end_ch_r <= wb[7:4];
      end
      if (wr_burst) begin
        mode_r <= wb == `ADCS_BURST_ON ? ADCS_MODE_BURST : ADCS_MODE_IDLE;
      end
      if (wr_ovs) begin
        ovs_n_r <= ovs_count(wb);
        timed_en_r <= 1'b1;
      end
      if (wr_cnt) begin
        if (wb == `ADCS_CNT_RUN_12 || wb == `ADCS_CNT_RUN_0) begin
          mode_r <= ADCS_MODE_TIMED;
        end else if (wb == `ADCS_CNT_ARM_12 || wb == `ADCS_CNT_ARM_0) begin
          mode_r <= ADCS_MODE_EXT_START;
          ext_started_r <= 1'b0;
        end
        use_c0_r <= wb[1];
      end
      // Only the first start edge counts; later ones change nothing
      if (mode_r == ADCS_MODE_EXT_START && es_rise && !ext_started_r) begin
        ext_started_r <= 1'b1;
      end
      if (wr_ext) begin
        if (wb == `ADCS_EXT_ARM) begin
          mode_r <= ADCS_MODE_EXT_TRIG;
          ext_run_r <= 1'b1;
        end else if (wb == `ADCS_EXT_SUSPEND) begin
          ext_run_r <= 1'b0;
        end
      end
      if (wr_gate) gate_r <= wb == `ADCS_GATE_ON;
    end
  end

  // Gain table, unity at reset and on the gain reset write
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || soft_rst || wr_gain_rst) begin
      gain_r <= `ADCS_GAIN_UNITY;
    end else if (wr_gain_lo) begin
      gain_r[15:0] <= io_in.wdata;
    end else if (wr_gain_hi) begin
      gain_r[31:16] <= io_in.wdata;
    end
  end
  wire [1:0] gain_sel = gain_r[{chan_r[2:0], 1'b0} +: 2];
  wire [1:0] gain_cur = chan_r[3] ? gain_r[16 + {chan_r[2:0], 1'b0} +: 2] : gain_sel;

  // ****************************************
  // Outputs
  // ****************************************
  logic [15:0] rdata_r;
  adcs_conv_t conv_r;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_r <= 16'h0000;
      conv_r <= '0;
    end else begin
      conv_r.start <= st_r == ADCS_SQ_REQ && may_req;
      conv_r.chan <= chan_r;
      conv_r.gain <= gain_cur;
      if (io_in.rd8 && io_in.addr == `ADCS_OFS_STATUS) begin
        rdata_r <= {13'h0000, f_full, f_half, f_empty};
      end else if (io_in.rd8 && io_in.addr == `ADCS_OFS_CHAN) begin
        rdata_r <= {12'h000, chan_r};
      end else if (rd_fifo) begin
        rdata_r <= f_empty ? 16'h0000 : mem[rp_r];
      end else begin
        rdata_r <= 16'h0000;
      end
    end
  end
  assign rdata_out = rdata_r;
  assign conv_out = conv_r;
  assign gate_enable_out = gate_r;
  assign fifo_half_full_flag_out = f_half;
endmodule

/* File: tb/adcs_seq_monitor.sv */
`timescale 1ns/1ns
// ****************
// Port checker
// ****************
module adcs_seq_monitor
  import adcs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire adcs_io_t io_in,
  input wire logic [15:0] rdata_out,
  input wire adcs_conv_t conv_out,
  input wire logic conv_done_in,
  input wire logic gate_enable_out,
  input wire logic fifo_half_full_flag_out
);
  logic busy_r;
  logic lim_v_r;
  logic [7:0] lim_r;
  logic [31:0] gain_r;
  // Host access decode; a board reset read clears what the host set up
  wire clr = !rst_n_in || (io_in.rd8 && io_in.addr == 5'h1d);
  wire w_lim = io_in.wr8 && io_in.addr == 5'h02;
  wire w_glo = io_in.wr16 && io_in.addr == 5'h04;
  wire w_ghi = io_in.wr16 && io_in.addr == 5'h06;
  wire w_grst = io_in.wr8 && io_in.addr == 5'h07;
  wire [31:0] gain_nxt = (clr || w_grst) ? 32'h0 : w_glo ? {gain_r[31:16], io_in.wdata} :
    w_ghi ? {io_in.wdata, gain_r[15:0]} : gain_r;
  // Shadow state; busy drops only on done or hard reset since a read reset leaves the converter running
  always_ff @(posedge mclk_in) begin
    busy_r <= rst_n_in && (conv_out.start || busy_r) && !conv_done_in;
    lim_v_r <= !clr && (w_lim || lim_v_r);
    lim_r <= w_lim ? io_in.wdata[7:0] : lim_r;
    gain_r <= gain_nxt;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  start_pulse_a: assert property (conv_out.start |=> !conv_out.start)
    else $error("conversion request held too long");
  one_at_time_a: assert property (conv_out.start |-> !busy_r)
    else $error("request while converter busy");
  chan_range_a: assert property (conv_out.start && lim_v_r |->
    conv_out.chan >= lim_r[3:0] && conv_out.chan <= lim_r[7:4])
    else $error("channel outside scan limits");
  gain_match_a: assert property (conv_out.start |->
    conv_out.gain == gain_r[{conv_out.chan, 1'b0} +: 2])
    else $error("wrong gain code for channel");
  gate_on_a: assert property (io_in.wr8 && io_in.addr == 5'h1e && io_in.wdata[7:0] == 8'h40
    |=> gate_enable_out)
    else $error("counter gate not enabled");
  gate_clear_a: assert property (io_in.rd8 && io_in.addr == 5'h1d |=> !gate_enable_out)
    else $error("board reset left gate on");
  chan_reload_a: assert property ($past(w_lim, 2) && io_in.rd8 && io_in.addr == 5'h0a
    |=> rdata_out == {12'h0, lim_r[3:0]})
    else $error("pointer not reloaded");
  half_status_a: assert property (io_in.rd8 && io_in.addr == 5'h08 |=>
    rdata_out[1] == $past(fifo_half_full_flag_out) && !(rdata_out[1] && rdata_out[0]))
    else $error("status half bit wrong");
endmodule
bind adcs_seq adcs_seq_monitor adcs_seq_monitor_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .io_in(io_in), .rdata_out(rdata_out), .conv_out(conv_out), .conv_done_in(conv_done_in),
  .gate_enable_out(gate_enable_out), .fifo_half_full_flag_out(fifo_half_full_flag_out));

/* File: tb/adcs_conv_model.sv */
`timescale 1ns/1ns
// ****************
// Converter model
// ****************
module adcs_conv_model
  import adcs_pkg::*;
#(
  parameter int DLY = 20
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire adcs_conv_t conv_in,
  output logic conv_done_out,
  output logic [15:0] conv_data_out
);
  int cnt_r;
  logic [5:0] tag_r;
  // Result names gain and channel; data toggles outside done so stale values never pass
  always_ff @(posedge mclk_in) begin
    conv_done_out <= 1'b0;
    conv_data_out <= ~conv_data_out;
    if (!rst_n_in) begin
      cnt_r <= 0;
      conv_data_out <= 16'h0;
    end else if (conv_in.start) begin
      cnt_r <= DLY;
      tag_r <= {conv_in.gain, conv_in.chan};
    end else if (cnt_r == 1) begin
      cnt_r <= 0;
      conv_done_out <= 1'b1;
      conv_data_out <= {8'hc0, 2'h0, tag_r};
    end else if (cnt_r > 1) begin
      cnt_r <= cnt_r - 1;
    end
  end
endmodule

/* File: tb/tb_adcs_seq.sv */
`timescale 1ns/1ns
module tb_adcs_seq;
  import adcs_pkg::*;
  logic mclk_in, rst_n_in, done, gate, half;
  logic [3:0] trg;
  logic [3:0] c;
  adcs_io_t io;
  adcs_conv_t conv;
  logic [15:0] rdata, cdata, v;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  logic [7:0] ovs_c [4] = '{8'h11, 8'h91, 8'h90, 8'h10};
  int ovs_n [4] = '{1, 2, 8, 16};
  // Small FIFO keeps the fill test short
  adcs_seq #(.FIFO_DEPTH(16), .DATA_W(16)) adcs_seq_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .io_in(io), .rdata_out(rdata), .cnt0_out_in(trg[0]), .cnt12_out_in(trg[1]),
    .ext_start_in(trg[2]), .ext_trig_in(trg[3]), .conv_out(conv), .conv_done_in(done),
    .conv_data_in(cdata), .gate_enable_out(gate), .fifo_half_full_flag_out(half));
  adcs_conv_model adcs_conv_model_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .conv_in(conv),
    .conv_done_out(done), .conv_data_out(cdata));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // ****************
  // Access tasks
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle; read data is taken in the cycle after the strobe
  task automatic acc(input logic [3:0] k, input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    io <= {k, a, d};
    @(posedge mclk_in);
    io <= '0;
    #1 v = rdata;
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    acc(4'h8, a, {8'h0, d});
  endtask
  task automatic rd8(input logic [4:0] a);
    acc(4'h4, a, 16'h0);
  endtask
  task automatic pop_exp(input logic [3:0] ch, input logic [1:0] g);
    // A write leaves v at zero, which would look like a non-empty FIFO
    v = 16'h1;
    for (int i = 0; i < 100 && v[0] !== 1'b0; i++) rd8(5'h08);
    acc(4'h2, 5'h00, 16'h0);
    chk(v, {8'hc0, 2'h0, g, ch});
    v = 16'h1;
  endtask
  // Count samples until empty; bounded so a stuck flag cannot hang the run
  task automatic drain();
    n = 0;
    rd8(5'h08);
    while (v[0] === 1'b0 && n < 40) begin
      acc(4'h2, 5'h00, 16'h0);
      n++;
      rd8(5'h08);
    end
    v = 16'h1;
  endtask
  task automatic step(input int k, input int e);
    @(posedge mclk_in);
    trg[k] <= 1'b1;
    repeat (4) @(posedge mclk_in);
    trg[k] <= 1'b0;
    repeat (500) @(posedge mclk_in);
    drain();
    if (e >= 0) chk(16'(n), 16'(e));
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #800000;
    n_fail++;
    print_verdict();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    rst_n_in = 1'b0;
    io = '0;
    trg = 4'h0;
    v = 16'h1;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd8(5'h08);
    chk(v & 16'h0007, 16'h0001);
    wr8(5'h02, 8'h52);
    rd8(5'h0a);
    chk(v, 16'h0002);
    acc(4'h1, 5'h04, 16'h00e4);
    for (int i = 0; i < 5; i++) begin
      c = 4'(2 + i % 4);
      wr8(5'h00, 8'h5a);
      pop_exp(c, c < 4 ? c[1:0] : 2'h0);
    end
    wr8(5'h07, 8'h00);
    wr8(5'h00, 8'h00);
    pop_exp(4'h3, 2'h0);
    $display("Test software done");
    for (int k = 0; k < 4; k++) begin
      rd8(5'h1d);
      wr8(5'h02, 8'h11);
      wr8(5'h1e, 8'h40);
      chk({15'h0, gate}, 16'h1);
      wr8(5'h1a, ovs_c[k]);
      wr8(5'h1b, k[0] ? 8'h03 : 8'h01);
      step(k[0] ? 0 : 1, ovs_n[k]);
    end
    rd8(5'h1d);
    wr8(5'h02, 8'h31);
    wr8(5'h1a, 8'h91);
    wr8(5'h1b, 8'h03);
    step(0, -1);
    wr8(5'h1b, 8'h03);
    trg[0] <= 1'b1;
    repeat (4) @(posedge mclk_in);
    trg[0] <= 1'b0;
    for (int i = 0; i < 6; i++) pop_exp(4'(1 + i / 2), 2'h0);
    $display("Test timed done");
    rd8(5'h1d);
    wr8(5'h02, 8'h00);
    wr8(5'h1a, 8'h11);
    wr8(5'h1b, 8'h00);
    step(1, 0);
    step(2, -1);
    step(1, 1);
    step(2, 0);
    step(1, 1);
    $display("Test external start done");
    rd8(5'h1d);
    wr8(5'h02, 8'h10);
    wr8(5'h1c, 8'h02);
    step(3, 2);
    trg[3] <= 1'b1;
    repeat (4) @(posedge mclk_in);
    trg[3] <= 1'b0;
    step(3, 2);
    wr8(5'h1c, 8'h00);
    step(3, 0);
    wr8(5'h1c, 8'h02);
    step(3, 2);
    $display("Test external trigger done");
    rd8(5'h1d);
    wr8(5'h02, 8'h73);
    wr8(5'h03, 8'h01);
    repeat (1000) @(posedge mclk_in);
    wr8(5'h03, 8'h00);
    step(0, -1);
    chk(16'(n >= 4 && n <= 6), 16'h1);
    wr8(5'h03, 8'h01);
    repeat (4500) @(posedge mclk_in);
    rd8(5'h08);
    chk(v & 16'h0007, 16'h0006);
    chk({15'h0, half}, 16'h1);
    wr8(5'h03, 8'h00);
    repeat (100) @(posedge mclk_in);
    for (int i = 0; i < 16; i++) pop_exp(4'h3, 2'h0);
    step(0, 0);
    $display("Test burst done");
    print_verdict();
  end
endmodule
